/* src/bfifo_map.svh */
// constants for the bidirectional queue pair: widths, depths, offsets, counts
`ifndef BFIFO_MAP_SVH
`define BFIFO_MAP_SVH

`define DATA_W 36
`define PTR_W 10
`define CNT_W 11
`define QUEUE_DEPTH 11'h400
`define SYNC_W 5

`define FS_SEL_8 2'h1
`define FS_SEL_16 2'h2
`define FS_SEL_64 2'h3
`define OFS_8 11'h008
`define OFS_16 11'h010
`define OFS_64 11'h040
`define OFS_PARALLEL_DFLT 11'h008

`define WAKE_EDGES 2'h2

`define MODE_PIN_STANDARD 1'h1

`endif

/* src/bfifo_pkg.sv */
// shared types and helper functions of the bidirectional queue pair
`include "bfifo_map.svh"

package bfifo_pkg;

    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`PTR_W-1:0] ptr_t;

    typedef enum logic {MODE_STANDARD, MODE_FALL_THROUGH} timing_mode_e;

    // preset offset from the two latched select bits
    function automatic count_t offset_decode(input logic [1:0] fs);
        count_t ofs;
        ofs = `OFS_PARALLEL_DFLT;
        case (fs)
            `FS_SEL_8: ofs = `OFS_8;
            `FS_SEL_16: ofs = `OFS_16;
            `FS_SEL_64: ofs = `OFS_64;
            default: ofs = `OFS_PARALLEL_DFLT;
        endcase
        return ofs;
    endfunction

    // active-low near flag: high only while the level is above the offset
    function automatic logic near_flag_n(input count_t level, input count_t ofs);
        return level > ofs;
    endfunction

endpackage

/* src/port_if.sv */
// synchronised view of one port's pins, passed from port_sync to the top
`timescale 1ns/1ps
`default_nettype none

interface port_if;
    import bfifo_pkg::*;
    logic strobe;
    logic sel_n;
    logic enable;
    logic wr_sel;
    word_t wdata;
    modport drive(output strobe, output sel_n, output enable, output wr_sel, output wdata);
    modport take(input strobe, input sel_n, input enable, input wr_sel, input wdata);
endinterface

`default_nettype wire

/* src/port_sync.sv */
// two-flop synchroniser for one port's pins and rising-edge strobe of its clock
`timescale 1ns/1ps
`default_nettype none
`include "bfifo_map.svh"

module port_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic port_clock,
    input wire logic select_n,
    input wire logic access_enable,
    input wire logic write_read_sel,
    input wire bfifo_pkg::word_t data_in,
    port_if.drive p
);
    import bfifo_pkg::*;

    logic [`DATA_W+3:0] stage1;
    logic [`DATA_W+3:0] stage2;
    logic clock_prev;
    logic [`DATA_W+3:0] raw;

    assign raw = {port_clock, select_n, access_enable, write_read_sel, data_in};

    // all pins travel together so data lines up with the clock edge
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            clock_prev <= 1'b0;
        end else if (ce) begin
            stage1 <= raw;
            stage2 <= stage1;
            clock_prev <= stage2[`DATA_W+3];
        end
    end

    // one strobe per port clock rising edge; port clock must run freely
    always_ff @(posedge clk) begin
        if (rst) begin
            p.strobe <= 1'b0;
            p.sel_n <= 1'b1;
            p.enable <= 1'b0;
            p.wr_sel <= 1'b0;
            p.wdata <= '0;
        end else if (ce) begin
            p.strobe <= stage2[`DATA_W+3] & ~clock_prev;
            p.sel_n <= stage2[`DATA_W+2];
            p.enable <= stage2[`DATA_W+1];
            p.wr_sel <= stage2[`DATA_W];
            p.wdata <= stage2[`DATA_W-1:0];
        end
    end
endmodule

`default_nettype wire

/* src/fifo_queue.sv */
// one direction of the pair: storage, pointers, occupancy and output register
`timescale 1ns/1ps
`default_nettype none
`include "bfifo_map.svh"

module fifo_queue (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    input wire logic fall_through,
    input wire logic wr,
    input wire bfifo_pkg::word_t wdata,
    input wire logic rd,
    output bfifo_pkg::word_t rdata,
    output bfifo_pkg::count_t words,
    output bfifo_pkg::count_t free,
    output logic avail,
    output logic full
);
    import bfifo_pkg::*;

    word_t mem [`QUEUE_DEPTH];
    ptr_t wptr;
    ptr_t rptr;
    count_t cnt;
    logic out_valid;
    wire stored = cnt != '0;
    wire can_wr = wr & ~full;
    wire can_rd = rd & (fall_through ? out_valid : stored);
    // fall-through refills the output register without a request
    wire load = fall_through ? (stored & (~out_valid | can_rd)) : can_rd;

    assign full = cnt == `QUEUE_DEPTH;
    assign avail = fall_through ? out_valid : stored;
    assign words = cnt + count_t'(out_valid);
    assign free = `QUEUE_DEPTH - cnt;

    // storage kept out of reset so it maps onto block memory
    always_ff @(posedge clk) begin
        if (ce && can_wr && !clr) begin
            mem[wptr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clr) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            out_valid <= 1'b0;
            rdata <= '0;
        end else if (ce) begin
            if (can_wr) begin
                wptr <= wptr + 1'b1;
            end
            if (load) begin
                rdata <= mem[rptr];
                rptr <= rptr + 1'b1;
            end
            cnt <= cnt + count_t'(can_wr) - count_t'(load);
            out_valid <= fall_through & (load | (out_valid & ~can_rd));
        end
    end
endmodule

`default_nettype wire

/* src/bidir_fifo_top.sv */
// bidirectional synchronous queue pair with per-port flags, top level
`timescale 1ns/1ps
`default_nettype none
`include "bfifo_map.svh"

module bidir_fifo_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic side_a_clock,
    input wire logic side_b_clock,
    input wire logic side_a_select_n,
    input wire logic side_b_select_n,
    input wire logic side_a_access_enable,
    input wire logic side_b_access_enable,
    input wire logic side_a_write_read_sel,
    input wire logic side_b_write_read_sel,
    input wire bfifo_pkg::word_t side_a_data_bus_in,
    output bfifo_pkg::word_t side_a_data_bus_out,
    output logic side_a_data_bus_oe_n,
    input wire bfifo_pkg::word_t side_b_data_bus_in,
    output bfifo_pkg::word_t side_b_data_bus_out,
    output logic side_b_data_bus_oe_n,
    input wire logic a_to_b_queue_reset_n,
    input wire logic b_to_a_queue_reset_n,
    input wire logic offset_select_bit0,
    input wire logic offset_select_bit1,
    input wire logic timing_mode_select,
    output logic port_a_near_empty_n,
    output logic port_b_near_empty_n,
    output logic port_a_near_full_n,
    output logic port_b_near_full_n,
    output logic side_a_empty_or_out_ready,
    output logic side_b_empty_or_out_ready,
    output logic side_a_full_or_in_ready,
    output logic side_b_full_or_in_ready
);
    import bfifo_pkg::*;

    port_if pa();
    port_if pb();

    port_sync u_sync_a (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .port_clock(side_a_clock),
        .select_n(side_a_select_n),
        .access_enable(side_a_access_enable),
        .write_read_sel(side_a_write_read_sel),
        .data_in(side_a_data_bus_in),
        .p(pa.drive)
    );

    port_sync u_sync_b (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .port_clock(side_b_clock),
        .select_n(side_b_select_n),
        .access_enable(side_b_access_enable),
        .write_read_sel(side_b_write_read_sel),
        .data_in(side_b_data_bus_in),
        .p(pb.drive)
    );

    // reset, offset-select and mode pins share one two-flop synchroniser
    logic [`SYNC_W-1:0] misc_s1;
    logic [`SYNC_W-1:0] misc_s2;
    wire [`SYNC_W-1:0] misc_raw = {a_to_b_queue_reset_n, b_to_a_queue_reset_n,
                                   offset_select_bit1, offset_select_bit0, timing_mode_select};
    wire ab_rst_n_s = misc_s2[4];
    wire ba_rst_n_s = misc_s2[3];
    wire [1:0] fs_s = misc_s2[2:1];
    wire mode_s = misc_s2[0];

    always_ff @(posedge clk) begin
        if (rst) begin
            misc_s1 <= '0;
            misc_s2 <= '0;
        end else if (ce) begin
            misc_s1 <= misc_raw;
            misc_s2 <= misc_s1;
        end
    end

    // mode and offsets
    timing_mode_e mode;
    logic ab_rst_n_prev;
    logic ba_rst_n_prev;
    count_t ofs_ab;
    count_t ofs_ba;
    wire ab_clr = ~ab_rst_n_s;
    wire ba_clr = ~ba_rst_n_s;
    wire fall_through = mode == MODE_FALL_THROUGH;
    wire any_reset = ab_clr | ba_clr;
    wire timing_mode_e pin_mode = (mode_s == `MODE_PIN_STANDARD) ? MODE_STANDARD
                                                                  : MODE_FALL_THROUGH;

    // mode follows the pin only during a queue reset; a pin change later is ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= MODE_STANDARD;
        end else if (ce && any_reset) begin
            mode <= pin_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ab_rst_n_prev <= 1'b0;
            ba_rst_n_prev <= 1'b0;
            ofs_ab <= `OFS_PARALLEL_DFLT;
            ofs_ba <= `OFS_PARALLEL_DFLT;
        end else if (ce) begin
            ab_rst_n_prev <= ab_rst_n_s;
            ba_rst_n_prev <= ba_rst_n_s;
            if (ab_rst_n_s && !ab_rst_n_prev) begin
                ofs_ab <= offset_decode(fs_s);
            end
            if (ba_rst_n_s && !ba_rst_n_prev) begin
                ofs_ba <= offset_decode(fs_s);
            end
        end
    end

    // transfer decode
    wire a_go = pa.strobe & ~pa.sel_n & pa.enable;
    wire b_go = pb.strobe & ~pb.sel_n & pb.enable;
    wire a_wr = a_go & pa.wr_sel;
    wire a_rd = a_go & ~pa.wr_sel;
    wire b_wr = b_go & ~pb.wr_sel;
    wire b_rd = b_go & pb.wr_sel;

    // input-ready wake-up: writes wait two writing-port edges after reset
    logic [1:0] ab_wake;
    logic [1:0] ba_wake;
    wire ab_awake = ab_wake == `WAKE_EDGES;
    wire ba_awake = ba_wake == `WAKE_EDGES;

    always_ff @(posedge clk) begin
        if (rst || ab_clr) begin
            ab_wake <= '0;
        end else if (ce && pa.strobe && !ab_awake) begin
            ab_wake <= ab_wake + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || ba_clr) begin
            ba_wake <= '0;
        end else if (ce && pb.strobe && !ba_awake) begin
            ba_wake <= ba_wake + 1'b1;
        end
    end

    // the two queues
    word_t ab_rdata;
    word_t ba_rdata;
    count_t ab_words;
    count_t ba_words;
    count_t ab_free;
    count_t ba_free;
    logic ab_avail;
    logic ba_avail;
    logic ab_full;
    logic ba_full;

    fifo_queue u_a_to_b_queue (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .clr(ab_clr),
        .fall_through(fall_through),
        .wr(a_wr & ab_awake),
        .wdata(pa.wdata),
        .rd(b_rd),
        .rdata(ab_rdata),
        .words(ab_words),
        .free(ab_free),
        .avail(ab_avail),
        .full(ab_full)
    );

    fifo_queue u_b_to_a_queue (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .clr(ba_clr),
        .fall_through(fall_through),
        .wr(b_wr & ba_awake),
        .wdata(pb.wdata),
        .rd(a_rd),
        .rdata(ba_rdata),
        .words(ba_words),
        .free(ba_free),
        .avail(ba_avail),
        .full(ba_full)
    );

    // flag levels
    wire ae_a_lvl = near_flag_n(ba_words, ofs_ba);
    wire ae_b_lvl = near_flag_n(ab_words, ofs_ab);
    wire af_a_lvl = near_flag_n(ab_free, ofs_ab);
    wire af_b_lvl = near_flag_n(ba_free, ofs_ba);
    wire ir_a_lvl = ab_awake & ~ab_full;
    wire ir_b_lvl = ba_awake & ~ba_full;

    // port A flags move only on port A edges, one edge behind the count
    always_ff @(posedge clk) begin
        if (rst) begin
            port_a_near_empty_n <= 1'b0;
            port_a_near_full_n <= 1'b1;
            side_a_empty_or_out_ready <= 1'b0;
            side_a_full_or_in_ready <= 1'b0;
        end else if (ce && pa.strobe) begin
            port_a_near_empty_n <= ~ba_clr & ae_a_lvl;
            side_a_empty_or_out_ready <= ~ba_clr & ba_avail;
            port_a_near_full_n <= ab_clr | af_a_lvl;
            side_a_full_or_in_ready <= ~ab_clr & ir_a_lvl;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port_b_near_empty_n <= 1'b0;
            port_b_near_full_n <= 1'b1;
            side_b_empty_or_out_ready <= 1'b0;
            side_b_full_or_in_ready <= 1'b0;
        end else if (ce && pb.strobe) begin
            port_b_near_empty_n <= ~ab_clr & ae_b_lvl;
            side_b_empty_or_out_ready <= ~ab_clr & ab_avail;
            port_b_near_full_n <= ba_clr | af_b_lvl;
            side_b_full_or_in_ready <= ~ba_clr & ir_b_lvl;
        end
    end

    // data ports; drive only while selected and reading
    wire a_drive = ~pa.sel_n & ~pa.wr_sel;
    wire b_drive = ~pb.sel_n & pb.wr_sel;

    always_ff @(posedge clk) begin
        if (rst) begin
            side_a_data_bus_out <= '0;
            side_b_data_bus_out <= '0;
            side_a_data_bus_oe_n <= 1'b1;
            side_b_data_bus_oe_n <= 1'b1;
        end else if (ce) begin
            side_a_data_bus_out <= ba_rdata;
            side_b_data_bus_out <= ab_rdata;
            side_a_data_bus_oe_n <= ~a_drive;
            side_b_data_bus_oe_n <= ~b_drive;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    a_near_empty_a: assert property ((pa.strobe && !ba_clr) |=>
        port_a_near_empty_n == $past(ae_a_lvl)) else $error("port A near-empty wrong");
    a_near_empty_b: assert property ((pb.strobe && !ab_clr) |=>
        port_b_near_empty_n == $past(ae_b_lvl)) else $error("port B near-empty wrong");
    a_near_full_a: assert property ((pa.strobe && !ab_clr) |=>
        port_a_near_full_n == $past(af_a_lvl)) else $error("port A near-full wrong");
    a_near_full_b: assert property ((pb.strobe && !ba_clr) |=>
        port_b_near_full_n == $past(af_b_lvl)) else $error("port B near-full wrong");
    a_mode_latch: assert property (any_reset |=>
        (fall_through == ($past(mode_s) != `MODE_PIN_STANDARD))) else $error("mode not taken");
    a_flag_hold: assert property (!pa.strobe |=>
        $stable(side_a_full_or_in_ready) && $stable(port_a_near_empty_n))
        else $error("port A flag moved off edge");
    a_select_gate: assert property ((pa.strobe && (pa.sel_n || !pa.enable) && !b_rd && !ab_clr)
        |=> ab_words <= $past(ab_words)) else $error("unselected write taken");
    a_drive_release: assert property (pb.sel_n |=>
        side_b_data_bus_oe_n) else $error("port B drives while deselected");
    a_reset_flags: assert property ((ab_clr && pa.strobe) |=>
        !side_a_full_or_in_ready && port_a_near_full_n) else $error("reset flags wrong");
    // a queue reset empties a full queue legally, so it is left out here
    a_full_ignore: assert property ((ab_full && !b_rd && !ab_clr) |=>
        ab_free == '0) else $error("write into full queue");

    c_a_to_b_word: cover property (a_wr ##[1:60] b_rd);
    c_fall_through_ready: cover property (fall_through && side_b_empty_or_out_ready);
    c_near_full: cover property (!port_a_near_full_n && side_a_full_or_in_ready);
endmodule

`default_nettype wire

/* verification/port_host.sv */
// far-side bus master for one port: free-running port clock and single transfers
`timescale 1ns/1ps
`default_nettype none

module port_host #(
    parameter int HALF = 4,
    parameter int PHASE = 0,
    parameter logic WRITE_LEVEL = 1'h1
) (
    input wire logic clk,
    output logic port_clock,
    output logic select_n,
    output logic access_enable,
    output logic write_read_sel,
    output bfifo_pkg::word_t data_out
);
    import bfifo_pkg::*;

    int cnt = PHASE;

    initial begin
        select_n = 1'h1;
        access_enable = 1'h0;
        write_read_sel = WRITE_LEVEL;
        data_out = 36'h0_0000_0000;
    end

    // runs between transfers too, flags need idle edges to settle
    always @(negedge clk) begin
        cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    end

    assign port_clock = (cnt >= HALF);

    // the count read here is still the old one, so no race with its update
    task automatic sync_fall();
        int i;
        for (i = 0; i < 2 * HALF; i++) begin
            @(negedge clk);
            if (cnt == 2 * HALF - 1) begin
                break;
            end
        end
    endtask

    // controls held one whole port period around the rising edge
    task automatic xfer(input logic wr, input word_t d, input logic sel_n, input logic en);
        sync_fall();
        select_n <= sel_n;
        access_enable <= en;
        write_read_sel <= wr ? WRITE_LEVEL : ~WRITE_LEVEL;
        data_out <= wr ? d : ~data_out;
        sync_fall();
        access_enable <= 1'h0;
        // released lines must not keep the last word
        data_out <= ~data_out;
    endtask

    task automatic deselect();
        sync_fall();
        select_n <= 1'h1;
    endtask
endmodule

`default_nettype wire

/* verification/bidir_fifo_top_tb.sv */
// self-checking bench for the bidirectional queue pair
`timescale 1ns/1ps
`default_nettype none

module bidir_fifo_top_tb;
    import bfifo_pkg::*;

    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic a_to_b_queue_reset_n = 1'h0;
    logic b_to_a_queue_reset_n = 1'h0;
    logic offset_select_bit0 = 1'h1;
    logic offset_select_bit1 = 1'h0;
    logic timing_mode_select = 1'h1;
    logic side_a_clock, side_b_clock, side_a_select_n, side_b_select_n;
    logic side_a_access_enable, side_b_access_enable;
    logic side_a_write_read_sel, side_b_write_read_sel;
    logic side_a_data_bus_oe_n, side_b_data_bus_oe_n;
    logic port_a_near_empty_n, port_b_near_empty_n, port_a_near_full_n, port_b_near_full_n;
    logic side_a_empty_or_out_ready, side_b_empty_or_out_ready;
    logic side_a_full_or_in_ready, side_b_full_or_in_ready;
    word_t side_a_data_bus_in, side_a_data_bus_out, side_b_data_bus_in, side_b_data_bus_out;
    int errors = 0;
    int checked = 0;
    int i, k, ofs, last;

    always #5 clk = ~clk;

    bidir_fifo_top DUT (
        .clk, .rst, .ce, .side_a_clock, .side_b_clock, .side_a_select_n, .side_b_select_n,
        .side_a_access_enable, .side_b_access_enable, .side_a_write_read_sel,
        .side_b_write_read_sel, .side_a_data_bus_in, .side_a_data_bus_out,
        .side_a_data_bus_oe_n, .side_b_data_bus_in, .side_b_data_bus_out,
        .side_b_data_bus_oe_n, .a_to_b_queue_reset_n, .b_to_a_queue_reset_n,
        .offset_select_bit0, .offset_select_bit1, .timing_mode_select,
        .port_a_near_empty_n, .port_b_near_empty_n, .port_a_near_full_n, .port_b_near_full_n,
        .side_a_empty_or_out_ready, .side_b_empty_or_out_ready,
        .side_a_full_or_in_ready, .side_b_full_or_in_ready
    );

    // different periods and phases keep the two ports unrelated
    port_host #(.HALF(4), .PHASE(1), .WRITE_LEVEL(1'h1)) host_a (
        .clk(clk), .port_clock(side_a_clock), .select_n(side_a_select_n),
        .access_enable(side_a_access_enable), .write_read_sel(side_a_write_read_sel),
        .data_out(side_a_data_bus_in)
    );
    port_host #(.HALF(5), .PHASE(7), .WRITE_LEVEL(1'h0)) host_b (
        .clk(clk), .port_clock(side_b_clock), .select_n(side_b_select_n),
        .access_enable(side_b_access_enable), .write_read_sel(side_b_write_read_sel),
        .data_out(side_b_data_bus_in)
    );

    function automatic word_t w(input logic b);
        return {35'h0_0000_0000, b};
    endfunction

    function automatic word_t pat(input int n);
        return 36'h5_a000_0000 ^ word_t'(n * 37);
    endfunction

    task automatic check(input word_t seen, input word_t exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // flags trail counts by one port edge, so wait past two slow periods
    task automatic settle();
        repeat (30) @(negedge clk);
    endtask

    task automatic queue_reset(input logic mode, input logic [1:0] fs);
        @(negedge clk);
        a_to_b_queue_reset_n = 1'h0;
        b_to_a_queue_reset_n = 1'h0;
        timing_mode_select = mode;
        offset_select_bit1 = fs[1];
        offset_select_bit0 = fs[0];
        repeat (60) @(negedge clk);
        check(w(side_a_full_or_in_ready), w(1'h0));
        check(w(port_b_near_full_n), w(1'h1));
        check(w(port_a_near_empty_n), w(1'h0));
        check(w(side_b_empty_or_out_ready), w(1'h0));
        a_to_b_queue_reset_n = 1'h1;
        b_to_a_queue_reset_n = 1'h1;
        repeat (45) @(negedge clk);
        check(w(side_a_full_or_in_ready), w(1'h1));
        check(w(side_b_full_or_in_ready), w(1'h1));
    endtask

    initial begin
        repeat (8) @(negedge clk);
        check(w(side_a_data_bus_oe_n), w(1'h1));
        check(w(port_a_near_full_n), w(1'h1));
        rst = 1'h0;
        queue_reset(1'h1, 2'h1);
        for (i = 1; i <= 1025; i++) begin
            host_a.xfer(1'h1, pat(i), 1'h0, 1'h1);
            if (i == 8 || i == 9 || i == 1015 || i == 1016 || i == 1025) begin
                settle();
                check(w(port_b_near_empty_n), w(i > 8));
                check(w(port_a_near_full_n), w(i < 1016));
                check(w(side_a_full_or_in_ready), w(i < 1024));
                check(w(side_b_empty_or_out_ready), w(1'h1));
            end
        end
        for (i = 1; i <= 1024; i++) begin
            host_b.xfer(1'h0, pat(0), 1'h0, 1'h1);
            repeat (3) @(negedge clk);
            check(side_b_data_bus_out, pat(i));
        end
        check(w(side_b_data_bus_oe_n), w(1'h0));
        settle();
        check(w(side_b_empty_or_out_ready), w(1'h0));
        check(w(port_a_near_full_n), w(1'h1));
        host_b.xfer(1'h0, pat(0), 1'h0, 1'h1);
        host_a.xfer(1'h1, pat(2000), 1'h1, 1'h1);
        host_a.xfer(1'h1, pat(2001), 1'h0, 1'h0);
        settle();
        check(w(side_b_empty_or_out_ready), w(1'h0));
        host_a.xfer(1'h1, pat(2002), 1'h0, 1'h1);
        settle();
        host_b.xfer(1'h0, pat(0), 1'h0, 1'h1);
        repeat (3) @(negedge clk);
        check(side_b_data_bus_out, pat(2002));
        host_b.deselect();
        repeat (8) @(negedge clk);
        check(w(side_b_data_bus_oe_n), w(1'h1));
        $display("test standard a to b done");
        for (k = 1; k < 4; k++) begin
            queue_reset(1'h1, k[1:0]);
            ofs = (k == 1) ? 8 : (k == 2) ? 16 : 64;
            last = (k == 1) ? 1016 : ofs + 1;
            for (i = 1; i <= last; i++) begin
                host_b.xfer(1'h1, pat(i), 1'h0, 1'h1);
                if (i == ofs || i == ofs + 1 || i == 1015 || i == 1016) begin
                    settle();
                    check(w(port_a_near_empty_n), w(i > ofs));
                    check(w(port_b_near_full_n), w(i < 1016));
                end
            end
        end
        $display("test offsets b to a done");
        queue_reset(1'h0, 2'h2);
        host_b.xfer(1'h1, pat(1), 1'h0, 1'h1);
        host_b.xfer(1'h1, pat(2), 1'h0, 1'h1);
        host_a.xfer(1'h0, pat(0), 1'h0, 1'h0);
        settle();
        check(w(side_a_empty_or_out_ready), w(1'h1));
        check(side_a_data_bus_out, pat(1));
        check(w(side_a_full_or_in_ready), w(1'h1));
        host_a.xfer(1'h0, pat(0), 1'h0, 1'h1);
        settle();
        check(side_a_data_bus_out, pat(2));
        // a read made while the clock enable is low must be lost
        ce = 1'h0;
        host_a.xfer(1'h0, pat(0), 1'h0, 1'h1);
        ce = 1'h1;
        settle();
        check(w(side_a_empty_or_out_ready), w(1'h1));
        host_a.xfer(1'h0, pat(0), 1'h0, 1'h1);
        settle();
        check(w(side_a_empty_or_out_ready), w(1'h0));
        $display("test fall-through done");
        test_done();
    end

    initial begin
        repeat (90000) @(negedge clk);
        errors++;
        $display("ERROR at %0t: run did not finish", $time);
        test_done();
    end
endmodule

`default_nettype wire
